// File: rtl/adc_ctrl_pkg.sv
/*
  Constants shared by the conversion control block: I/O offsets, field
  positions, reset values and code values.
  Assumes byte-wide I/O accesses whose byte offset comes from the host
  interface already decoded down to the card's register window.
*/
package adc_ctrl_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned CHAN_W    = 4;
  localparam int unsigned NUM_CHAN  = 16;
  localparam int unsigned GAIN_W    = 3;
  localparam int unsigned SAMPLE_W  = 12;
  localparam int unsigned TIMER_W   = 16;

  // I/O offsets
  localparam logic [7:0] OFS_DATA_LO     = 8'h00;
  localparam logic [7:0] OFS_DATA_HI     = 8'h01;
  localparam logic [7:0] OFS_EDO         = 8'h04;
  localparam logic [7:0] OFS_CHAN_MUX    = 8'h06;
  localparam logic [7:0] OFS_GAIN        = 8'h08;
  localparam logic [7:0] OFS_MODE        = 8'h0A;
  localparam logic [7:0] OFS_SW_TRIG     = 8'h0E;
  localparam logic [7:0] OFS_TIMER_ZERO  = 8'h40;
  localparam logic [7:0] OFS_TIMER_ONE   = 8'h42;
  localparam logic [7:0] OFS_TIMER_TWO   = 8'h44;
  localparam logic [7:0] OFS_TIMER_CTRL  = 8'h46;

  // Mode register fields
  localparam int unsigned MODE_AUTO_SCAN_BIT = 0;
  localparam int unsigned MODE_PACER_BIT     = 1;
  localparam int unsigned MODE_EXT_BIT       = 2;
  localparam int unsigned MODE_PRETRIG_BIT   = 3;
  localparam int unsigned MODE_W             = 4;

  // Status read-back fields
  localparam int unsigned STAT_IDLE_BIT = 7;

  // External digital output register fields
  localparam int unsigned EDO_MODE_LSB = 4;
  localparam logic [1:0]  EDO_MODE_IN  = 2'h1;
  localparam logic [1:0]  EDO_MODE_VAL = 2'h2;
  localparam logic [1:0]  EDO_MODE_CHN = 2'h3;

  // Timer control byte: counter select field
  localparam int unsigned CTRL_SEL_LSB = 6;

  // Gain codes
  localparam logic [2:0] GAIN_X1  = 3'h0;
  localparam logic [2:0] GAIN_X2  = 3'h1;
  localparam logic [2:0] GAIN_X4  = 3'h2;
  localparam logic [2:0] GAIN_X8  = 3'h3;
  localparam logic [2:0] GAIN_X16 = 3'h4;

  // Reset values
  localparam logic [3:0] MODE_RESET  = 4'h0;
  localparam logic [7:0] MUX_RESET   = 8'h00;
  localparam logic [2:0] GAIN_RESET  = GAIN_X1;
  localparam logic [3:0] EDO_RESET   = 4'h0;
  localparam logic [1:0] EDOM_RESET  = EDO_MODE_IN;

endpackage : adc_ctrl_pkg

// File: rtl/sync_edge.sv
/*
  Two-stage synchroniser with a falling-edge detector on each bit.
  Assumes the inputs are asynchronous to core_clk_in.
*/
`timescale 1ns/1ns
module sync_edge #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // Inputs idle high so a pin held high at reset gives no edge
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta     <= '1;
      sync_out <= '1;
      prev     <= '1;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
      prev     <= sync_out;
    end
  end

  assign fall_out = prev & ~sync_out;

endmodule : sync_edge

// File: rtl/timer_counter.sv
/*
  One 16-bit down counter of the timer block, rate-generator style.
  Loaded low byte then high byte; read low byte then high byte.
  Assumes count_en_in is synchronous to the core clock; held high, it counts every cycle.
*/
`timescale 1ns/1ns
module timer_counter (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       count_en_in,
  input  wire logic       load_wr_in,
  input  wire logic       read_in,
  input  wire logic       ptr_clear_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  output logic            tick_out
);

  logic [adc_ctrl_pkg::TIMER_W-1:0] reload;
  logic [adc_ctrl_pkg::TIMER_W-1:0] count;
  logic                             wr_hi;
  logic                             rd_hi;
  logic                             armed;

  // Counting starts only once both bytes are loaded
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reload   <= '0;
      count    <= '0;
      armed    <= 1'b0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (load_wr_in && wr_hi)
      begin
        reload[15:8] <= wdata_in;
        count        <= {wdata_in, reload[7:0]};
        armed        <= 1'b1;
      end
      else
      begin
        if (load_wr_in)
          reload[7:0] <= wdata_in;
        if (armed && count_en_in)
        begin
          if (count == 16'h0001)
          begin
            count    <= reload;
            tick_out <= 1'b1;
          end
          else
            count <= count - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_hi <= 1'b0;
      rd_hi <= 1'b0;
    end
    else if (ptr_clear_in)
    begin
      wr_hi <= 1'b0;
      rd_hi <= 1'b0;
    end
    else
    begin
      if (load_wr_in)
        wr_hi <= ~wr_hi;
      if (read_in)
        rd_hi <= ~rd_hi;
    end
  end

  assign rdata_out = rd_hi ? count[15:8] : count[7:0];

endmodule : timer_counter

// File: rtl/adc_trigger_scan_control.sv
/*
  Conversion control: channel select with auto-scan, trigger source
  choice (software write, cascaded timer pacer, external falling edge),
  shared gain, external digital output nibble, timer register map.
  Assumes a byte-wide I/O port on the core clock, a converter that pulses
  adc_done_in with its sample, and an asynchronous external trigger pin.
*/
`timescale 1ns/1ns
// Operation
// - Timer block occupies four locations: three counters RW, control WO.
// - Control byte location accepts writes only; reading it returns zero.
// - Each trigger edge starts one conversion of the selected channel.
// - Sixteen single-ended inputs, selected by a 4-bit number.
// - Auto-scan off: convert only the channel in the mux register.
// - Auto-scan on: mux register value is the scan's last channel.
// - Scan advances per trigger, wraps end to zero, until scan cleared.
// - Mux register is 8 bits; low nibble drives the input multiplexer.
// - Upper mux nibble can be driven onto external digital output pins.
// - Data register returns converted channel number with the sample.
// - Gain codes select 1, 2, 4, 8 or 16; gain 1 is widest range.
// - One gain setting applies to all channels, also while scanning.
// - External source selected: software writes and pacer ticks ignored.
// - Internal, pacer off: any software trigger write starts a conversion.
// - Internal, pacer on: cascaded timer counters trigger at fixed rate.
// - External source: each falling edge of the trigger pin starts one.
// - Trigger choice is independent of transfer and interrupt settings.
// - Pacer bit 0 picks software, 1 picks pacer; source bit 1 external.
module adc_trigger_scan_control (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  io_addr_in,
  input  wire logic        io_wr_in,
  input  wire logic        io_rd_in,
  input  wire logic [7:0]  io_wdata_in,
  output logic      [7:0]  io_rdata_out,
  input  wire logic        external_trigger_in,
  input  wire logic        adc_done_in,
  input  wire logic [11:0] adc_sample_in,
  output logic             conv_start_out,
  output logic      [3:0]  mux_select_out,
  output logic      [2:0]  gain_select_out,
  input  wire logic [3:0]  ext_digital_out_pins_in,
  output logic      [3:0]  ext_digital_out_pins_out,
  output logic             ext_digital_oe_out
);

  logic [adc_ctrl_pkg::MODE_W-1:0]   mode;
  logic [7:0]                        chan_mux;
  logic [adc_ctrl_pkg::GAIN_W-1:0]   gain;
  logic [3:0]                        edo_value;
  logic [1:0]                        edo_mode;
  logic [adc_ctrl_pkg::CHAN_W-1:0]   scan_ptr;
  logic                              scan_prev;
  logic [15:0]                       data_word;
  logic                              converting;

  logic                              auto_scan_enable;
  logic                              pacer_trigger_select;
  logic                              trigger_source_external;
  logic                              sw_trig_wr;
  logic                              internal_trig;
  logic                              trigger;
  logic [adc_ctrl_pkg::CHAN_W-1:0]   active_chan;
  logic [adc_ctrl_pkg::CHAN_W-1:0]   scan_end;

  logic [2:0]                        tmr_wr;
  logic [2:0]                        tmr_rd;
  logic [2:0]                        tmr_tick;
  logic [7:0]                        tmr_rdata [3];
  logic                              tmr_ctrl_wr;
  logic [2:0]                        tmr_ptr_clr;

  logic                              ext_fall;
  logic [3:0]                        edo_in_sync;

  assign auto_scan_enable =
    mode[adc_ctrl_pkg::MODE_AUTO_SCAN_BIT];
  assign pacer_trigger_select =
    mode[adc_ctrl_pkg::MODE_PACER_BIT];
  assign trigger_source_external =
    mode[adc_ctrl_pkg::MODE_EXT_BIT];

  // Register writes
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mode      <= adc_ctrl_pkg::MODE_RESET;
      chan_mux  <= adc_ctrl_pkg::MUX_RESET;
      gain      <= adc_ctrl_pkg::GAIN_RESET;
      edo_value <= adc_ctrl_pkg::EDO_RESET;
      edo_mode  <= adc_ctrl_pkg::EDOM_RESET;
    end
    else if (io_wr_in)
    begin
      unique case (io_addr_in)
        adc_ctrl_pkg::OFS_MODE:
          mode <= io_wdata_in[adc_ctrl_pkg::MODE_W-1:0];
        adc_ctrl_pkg::OFS_CHAN_MUX:
          chan_mux <= io_wdata_in;
        adc_ctrl_pkg::OFS_GAIN:
          gain <= io_wdata_in[adc_ctrl_pkg::GAIN_W-1:0];
        adc_ctrl_pkg::OFS_EDO:
        begin
          edo_value <= io_wdata_in[3:0];
          edo_mode  <= io_wdata_in[adc_ctrl_pkg::EDO_MODE_LSB +: 2];
        end
        default:
          ;
      endcase
    end
  end

  // Timer block: three counters plus a write-only control byte
  assign tmr_ctrl_wr =
    io_wr_in && (io_addr_in == adc_ctrl_pkg::OFS_TIMER_CTRL);

  always_comb
  begin
    tmr_wr      = 3'h0;
    tmr_rd      = 3'h0;
    tmr_ptr_clr = 3'h0;
    unique case (io_addr_in)
      adc_ctrl_pkg::OFS_TIMER_ZERO:
      begin
        tmr_wr[0] = io_wr_in;
        tmr_rd[0] = io_rd_in;
      end
      adc_ctrl_pkg::OFS_TIMER_ONE:
      begin
        tmr_wr[1] = io_wr_in;
        tmr_rd[1] = io_rd_in;
      end
      adc_ctrl_pkg::OFS_TIMER_TWO:
      begin
        tmr_wr[2] = io_wr_in;
        tmr_rd[2] = io_rd_in;
      end
      default:
        ;
    endcase
    // Control byte restarts the byte order of the counter it selects
    if (tmr_ctrl_wr)
    begin
      unique case (io_wdata_in[adc_ctrl_pkg::CTRL_SEL_LSB +: 2])
        2'h0:    tmr_ptr_clr[0] = 1'b1;
        2'h1:    tmr_ptr_clr[1] = 1'b1;
        2'h2:    tmr_ptr_clr[2] = 1'b1;
        default: tmr_ptr_clr    = 3'h0;
      endcase
    end
  end

  // Counter 1 runs off the core clock, counter 2 off counter 1's tick
  timer_counter u_timer_zero (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .count_en_in  (1'b1),
    .load_wr_in   (tmr_wr[0]),
    .read_in      (tmr_rd[0]),
    .ptr_clear_in (tmr_ptr_clr[0]),
    .wdata_in     (io_wdata_in),
    .rdata_out    (tmr_rdata[0]),
    .tick_out     (tmr_tick[0])
  );

  timer_counter u_timer_one (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .count_en_in  (1'b1),
    .load_wr_in   (tmr_wr[1]),
    .read_in      (tmr_rd[1]),
    .ptr_clear_in (tmr_ptr_clr[1]),
    .wdata_in     (io_wdata_in),
    .rdata_out    (tmr_rdata[1]),
    .tick_out     (tmr_tick[1])
  );

  timer_counter u_timer_two (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .count_en_in  (tmr_tick[1]),
    .load_wr_in   (tmr_wr[2]),
    .read_in      (tmr_rd[2]),
    .ptr_clear_in (tmr_ptr_clr[2]),
    .wdata_in     (io_wdata_in),
    .rdata_out    (tmr_rdata[2]),
    .tick_out     (tmr_tick[2])
  );

  sync_edge #(
    .WIDTH (1)
  ) u_ext_trig_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .async_in    (external_trigger_in),
    .sync_out    (),
    .fall_out    (ext_fall)
  );

  sync_edge #(
    .WIDTH (4)
  ) u_edo_in_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .async_in    (ext_digital_out_pins_in),
    .sync_out    (edo_in_sync),
    .fall_out    ()
  );

  // Trigger source selection; nothing else in the block feeds it
  assign sw_trig_wr =
    io_wr_in && (io_addr_in == adc_ctrl_pkg::OFS_SW_TRIG);
  assign internal_trig =
    pacer_trigger_select ? tmr_tick[2] : sw_trig_wr;
  assign trigger = trigger_source_external
    ? ext_fall
    : internal_trig;

  // Channel choice
  assign scan_end    = chan_mux[adc_ctrl_pkg::CHAN_W-1:0];
  assign active_chan = auto_scan_enable
    ? scan_ptr
    : chan_mux[adc_ctrl_pkg::CHAN_W-1:0];

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      scan_ptr  <= '0;
      scan_prev <= 1'b0;
    end
    else
    begin
      scan_prev <= auto_scan_enable;
      if (auto_scan_enable && !scan_prev)
        scan_ptr <= '0;
      else if (auto_scan_enable && trigger)
      begin
        // Compare with >= so a shortened end channel still wraps
        if (scan_ptr >= scan_end)
          scan_ptr <= '0;
        else
          scan_ptr <= scan_ptr + 4'h1;
      end
    end
  end

  // Start pulse and mux select move together, so the select is stable
  // for the whole conversion even though the scan pointer moves on
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      conv_start_out <= 1'b0;
      mux_select_out <= '0;
      converting     <= 1'b0;
    end
    else
    begin
      conv_start_out <= trigger;
      if (trigger)
        mux_select_out <= active_chan;
      if (trigger)
        converting <= 1'b1;
      else if (adc_done_in)
        converting <= 1'b0;
    end
  end

  // Sample tagged with the channel it came from
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      data_word <= 16'h0000;
    else if (adc_done_in)
      data_word <= {adc_sample_in, mux_select_out};
  end

  // Gain is a single register, never touched by the scan logic
  assign gain_select_out = gain;

  // External digital output pins
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ext_digital_out_pins_out <= 4'h0;
      ext_digital_oe_out       <= 1'b0;
    end
    else
    begin
      unique case (edo_mode)
        adc_ctrl_pkg::EDO_MODE_VAL:
        begin
          ext_digital_out_pins_out <= edo_value;
          ext_digital_oe_out       <= 1'b1;
        end
        adc_ctrl_pkg::EDO_MODE_CHN:
        begin
          ext_digital_out_pins_out <= chan_mux[7:4];
          ext_digital_oe_out       <= 1'b1;
        end
        default:
        begin
          ext_digital_out_pins_out <= 4'h0;
          ext_digital_oe_out       <= 1'b0;
        end
      endcase
    end
  end

  // Read data, registered; unmapped and write-only locations read zero
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      io_rdata_out <= 8'h00;
    else if (io_rd_in)
    begin
      unique case (io_addr_in)
        adc_ctrl_pkg::OFS_DATA_LO:
          io_rdata_out <= data_word[7:0];
        adc_ctrl_pkg::OFS_DATA_HI:
          io_rdata_out <= data_word[15:8];
        adc_ctrl_pkg::OFS_EDO:
          io_rdata_out <= {ext_digital_out_pins_out, edo_in_sync};
        adc_ctrl_pkg::OFS_GAIN:
        begin
          io_rdata_out <= 8'h00;
          io_rdata_out[adc_ctrl_pkg::STAT_IDLE_BIT] <= ~converting;
          io_rdata_out[adc_ctrl_pkg::GAIN_W-1:0]    <= gain;
        end
        adc_ctrl_pkg::OFS_MODE:
          io_rdata_out <= {4'h0, mode};
        adc_ctrl_pkg::OFS_TIMER_ZERO:
          io_rdata_out <= tmr_rdata[0];
        adc_ctrl_pkg::OFS_TIMER_ONE:
          io_rdata_out <= tmr_rdata[1];
        adc_ctrl_pkg::OFS_TIMER_TWO:
          io_rdata_out <= tmr_rdata[2];
        default:
          io_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule : adc_trigger_scan_control

// File: testbench/adc_conv_model.sv
/*
  Converter stand-in: done pulse and sample lat_in + 1 cycles after the edge that samples start.
  Assumes starts arrive on the core clock.
*/
`timescale 1ns/1ns
module adc_conv_model (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        start_in,
  input  wire logic [3:0]  chan_in,
  input  wire logic [3:0]  lat_in,
  output logic             done_out,
  output logic      [11:0] sample_out
);
  logic [3:0] cnt;
  logic [3:0] chan;
  logic       busy;
  // Outside the done cycle the sample bus toggles, so stale data fails
  always_ff @(posedge core_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      busy       <= 1'b0;
      cnt        <= 4'h0;
      chan       <= 4'h0;
      done_out   <= 1'b0;
      sample_out <= 12'h000;
    end
    else
    begin
      done_out   <= 1'b0;
      sample_out <= ~sample_out;
      if (start_in)
      begin
        busy <= 1'b1;
        cnt  <= lat_in;
        chan <= chan_in;
      end
      else if (busy && cnt == 4'h0)
      begin
        busy       <= 1'b0;
        done_out   <= 1'b1;
        sample_out <= {chan, 8'h5A};
      end
      else if (busy)
        cnt <= cnt - 4'h1;
    end
endmodule : adc_conv_model

// File: testbench/adc_scan_chk.sv
/*
  Checker on the top ports: triggers, scan order, gain, pins.
  Assumes one-cycle host strobes; bound to the control block.
*/
`timescale 1ns/1ns
module adc_scan_chk (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic [7:0] io_addr_in,
  input wire logic       io_wr_in,
  input wire logic       io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic       external_trigger_in,
  input wire logic       conv_start_out,
  input wire logic [3:0] mux_select_out,
  input wire logic [2:0] gain_select_out,
  input wire logic [3:0] ext_digital_out_pins_out,
  input wire logic       ext_digital_oe_out
);
  logic [3:0] mode;
  logic [7:0] mux;
  logic [3:0] last;
  logic       seen;
  logic [5:0] hist;
  logic       sw_wr;
  logic       fell;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  assign sw_wr = io_wr_in && io_addr_in == adc_ctrl_pkg::OFS_SW_TRIG;
  // Older pin sample high, newer low: a fall within the sync delay
  assign fell = |(hist[5:1] & ~hist[4:0]);

  always_ff @(posedge core_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      mode <= 4'h0;
      mux  <= 8'h00;
    end
    else if (io_wr_in && io_addr_in == adc_ctrl_pkg::OFS_MODE)
      mode <= io_wdata_in[3:0];
    else if (io_wr_in && io_addr_in == adc_ctrl_pkg::OFS_CHAN_MUX)
      mux <= io_wdata_in;

  // Previous scan channel; forgotten whenever scan is off
  always_ff @(posedge core_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      seen <= 1'b0;
      last <= 4'h0;
      hist <= 6'h3F;
    end
    else
    begin
      seen <= mode[0] && (seen || conv_start_out);
      hist <= {hist[4:0], external_trigger_in};
      if (conv_start_out)
        last <= mux_select_out;
    end

  property p_sw_start;
    sw_wr && mode[2:1] == 2'b00 |=> conv_start_out;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software write gave no start");

  property p_sw_ignored;
    sw_wr && mode[2] && (&hist) && external_trigger_in |=> !conv_start_out;
  endproperty
  a_sw_ignored: assert property (p_sw_ignored)
    else $error("software write started in external mode");

  property p_ext_cause;
    conv_start_out && mode[2] |-> fell;
  endproperty
  a_ext_cause: assert property (p_ext_cause)
    else $error("external start without pin fall");

  property p_fixed_chan;
    conv_start_out && !mode[0] |-> mux_select_out == mux[3:0];
  endproperty
  a_fixed_chan: assert property (p_fixed_chan)
    else $error("fixed channel differs from mux register");

  property p_scan_first;
    conv_start_out && mode[0] && !seen |-> mux_select_out == 4'h0;
  endproperty
  a_scan_first: assert property (p_scan_first)
    else $error("scan did not begin at channel zero");

  property p_scan_step;
    conv_start_out && mode[0] && seen |->
      mux_select_out == ((last >= mux[3:0]) ? 4'h0 : last + 4'h1);
  endproperty
  a_scan_step: assert property (p_scan_step)
    else $error("scan step wrong");

  property p_gain_load;
    io_wr_in && io_addr_in == adc_ctrl_pkg::OFS_GAIN |=>
      {5'h00, gain_select_out} == ($past(io_wdata_in) & 8'h07);
  endproperty
  a_gain_load: assert property (p_gain_load)
    else $error("gain code not loaded");

  property p_gain_hold;
    !(io_wr_in && io_addr_in == adc_ctrl_pkg::OFS_GAIN) |=>
      $stable(gain_select_out);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain changed without a write");

  property p_ctrl_read;
    io_rd_in && io_addr_in == adc_ctrl_pkg::OFS_TIMER_CTRL |=>
      io_rdata_out == 8'h00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control byte read not zero");

  property p_pins_chan;
    io_wr_in && io_addr_in == adc_ctrl_pkg::OFS_EDO &&
      io_wdata_in[5:4] == adc_ctrl_pkg::EDO_MODE_CHN |-> ##2
      ext_digital_oe_out && ext_digital_out_pins_out == mux[7:4];
  endproperty
  a_pins_chan: assert property (p_pins_chan)
    else $error("pins do not show upper mux nibble");

  c_wrap: cover property (conv_start_out && seen && mux_select_out == 4'h0);
  c_ext: cover property (conv_start_out && mode[2]);
  c_pacer: cover property (conv_start_out && mode[1]);
endmodule : adc_scan_chk

bind adc_trigger_scan_control adc_scan_chk u_chk (.*);

// File: testbench/test_adc_trigger_scan_control.sv
/*
  Bench: I/O tasks and one sequence per feature.
  Assumes the offsets of adc_ctrl_pkg.
*/
`timescale 1ns/1ns
module test_adc_trigger_scan_control;
  logic        core_clk_in;
  logic        arst_n_in;
  logic [7:0]  io_addr_in;
  logic        io_wr_in;
  logic        io_rd_in;
  logic [7:0]  io_wdata_in;
  logic [7:0]  io_rdata_out;
  logic        external_trigger_in;
  logic        adc_done_in;
  logic [11:0] adc_sample_in;
  logic        conv_start_out;
  logic [3:0]  mux_select_out;
  logic [2:0]  gain_select_out;
  logic [3:0]  ext_digital_out_pins_in;
  logic [3:0]  ext_digital_out_pins_out;
  logic        ext_digital_oe_out;
  logic [3:0]  lat;
  logic [7:0]  rd;
  int          fail_count;
  int          comparisons;
  int          n;
  wire  [7:0]  pin_view = {3'h0, ext_digital_oe_out, ext_digital_out_pins_out};

  adc_trigger_scan_control u_dut (.*);
  adc_conv_model u_conv (
    .core_clk_in, .arst_n_in, .start_in(conv_start_out),
    .chan_in(mux_select_out), .lat_in(lat), .done_out(adc_done_in),
    .sample_out(adc_sample_in));

  initial
  begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic stall(input string w);
    fail_count++;
    $display("FAIL %s expected event seen timeout", w);
    test_done();
  endtask : stall

  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    io_addr_in  = a;
    io_wdata_in = d;
    io_wr_in    = 1'b1;
    @(negedge core_clk_in);
    io_wr_in = 1'b0;
  endtask : io_wr

  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    io_addr_in = a;
    io_rd_in   = 1'b1;
    @(negedge core_clk_in);
    io_rd_in = 1'b0;
    d        = io_rdata_out;
  endtask : io_rd

  // Samples now, then per falling edge; cyc is lim + 1 if none
  task automatic wait_start(input int lim, input bit must, output int cyc);
    for (cyc = 1; cyc <= lim; cyc++)
    begin
      if (conv_start_out === 1'b1)
        return;
      @(negedge core_clk_in);
    end
    if (must)
      stall("start");
  endtask : wait_start

  task automatic fire;
    io_wr(8'h0E, 8'hFF);
    wait_start(4, 1'b1, n);
  endtask : fire

  task automatic wait_idle;
    for (int k = 0; k < 40; k++)
    begin
      io_rd(8'h08, rd);
      if (rd[7] === 1'b1)
        return;
    end
    stall("idle");
  endtask : wait_idle

  initial
  begin
    arst_n_in               = 1'b0;
    io_addr_in              = 8'h00;
    io_wr_in                = 1'b0;
    io_rd_in                = 1'b0;
    io_wdata_in             = 8'h00;
    external_trigger_in     = 1'b1;
    ext_digital_out_pins_in = 4'h6;
    lat                     = 4'h0;
    fail_count              = 0;
    comparisons             = 0;
    repeat (4) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    io_rd(8'h0A, rd);
    chk("mode", {4'h0, adc_ctrl_pkg::MODE_RESET}, rd);
    io_rd(8'h08, rd);
    chk("status", {5'h10, adc_ctrl_pkg::GAIN_RESET}, rd & 8'h87);
    chk("drive", 8'h00, {7'h00, ext_digital_oe_out});
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      lat = i[3:0];
      io_wr(8'h06, {4'hF - i[3:0], i[3:0]});
      fire();
      chk("channel", {4'h0, i[3:0]}, {4'h0, mux_select_out});
      wait_idle();
      io_rd(8'h00, rd);
      chk("data low", {4'hA, i[3:0]}, rd);
      io_rd(8'h01, rd);
      chk("data high", {i[3:0], 4'h5}, rd);
    end
    $display("test channel done");
    for (int g = 0; g < 5; g++)
    begin
      io_wr(8'h08, g[7:0]);
      chk("gain out", g[7:0], {5'h00, gain_select_out});
      io_rd(8'h08, rd);
      chk("gain read", g[7:0], rd & 8'h07);
    end
    io_wr(8'h08, {5'h00, adc_ctrl_pkg::GAIN_X8});
    $display("test gain done");
    io_wr(8'h06, 8'h03);
    io_wr(8'h0A, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      fire();
      chk("scan", 8'(i % 4), {4'h0, mux_select_out});
      chk("scan gain", {5'h00, adc_ctrl_pkg::GAIN_X8},
          {5'h00, gain_select_out});
    end
    io_wr(8'h0A, 8'h00);
    io_wr(8'h0A, 8'h01);
    fire();
    chk("rescan", 8'h00, {4'h0, mux_select_out});
    $display("test scan done");
    io_wr(8'h0A, 8'h06);
    io_wr(8'h0E, 8'hFF);
    wait_start(10, 1'b0, n);
    chk("ignored write", 8'h0B, n[7:0]);
    external_trigger_in = 1'b0;
    wait_start(8, 1'b1, n);
    chk("pin channel", 8'h03, {4'h0, mux_select_out});
    @(negedge core_clk_in);
    wait_start(10, 1'b0, n);
    chk("single start", 8'h0B, n[7:0]);
    external_trigger_in = 1'b1;
    wait_start(10, 1'b0, n);
    chk("pin rise", 8'h0B, n[7:0]);
    io_wr(8'h0A, 8'h00);
    external_trigger_in = 1'b0;
    wait_start(10, 1'b0, n);
    chk("pin ignored", 8'h0B, n[7:0]);
    external_trigger_in = 1'b1;
    $display("test external done");
    io_wr(8'h06, 8'hC3);
    io_wr(8'h04, {2'h0, adc_ctrl_pkg::EDO_MODE_VAL, 4'hA});
    @(negedge core_clk_in);
    chk("pins value", 8'h1A, pin_view);
    io_wr(8'h04, {2'h0, adc_ctrl_pkg::EDO_MODE_CHN, 4'h0});
    @(negedge core_clk_in);
    chk("pins chan", 8'h1C, pin_view);
    io_rd(8'h04, rd);
    chk("pins read", 8'hC6, rd);
    io_wr(8'h04, {2'h0, adc_ctrl_pkg::EDO_MODE_IN, 4'hA});
    @(negedge core_clk_in);
    chk("pins off", 8'h00, pin_view);
    $display("test pins done");
    io_wr(8'h46, 8'h80);
    io_wr(8'h44, 8'h34);
    io_wr(8'h44, 8'h12);
    io_rd(8'h44, rd);
    chk("count low", 8'h34, rd);
    io_rd(8'h44, rd);
    chk("count high", 8'h12, rd);
    io_rd(8'h46, rd);
    chk("control read", 8'h00, rd);
    io_wr(8'h46, 8'h80);
    io_wr(8'h44, 8'h03);
    io_wr(8'h44, 8'h00);
    io_wr(8'h46, 8'h40);
    io_wr(8'h42, 8'h04);
    io_wr(8'h42, 8'h00);
    io_wr(8'h0A, 8'h02);
    wait_start(40, 1'b1, n);
    @(negedge core_clk_in);
    wait_start(40, 1'b1, n);
    chk("pacer period", 8'h0C, n[7:0]);
    io_wr(8'h0E, 8'hFF);
    wait_start(6, 1'b0, n);
    chk("write in pacer", 8'h07, n[7:0]);
    io_wr(8'h0A, 8'h00);
    wait_start(30, 1'b0, n);
    chk("pacer off", 8'h1F, n[7:0]);
    $display("test timer done");
    test_done();
  end
endmodule : test_adc_trigger_scan_control
